// ---- common/sei_defines.svh ----
// register indices, field masks, reset values for the management irq enable stage
`ifndef SEI_DEFINES_SVH
`define SEI_DEFINES_SVH
// register indices; byte address is four times the index
`define SEI_IDX_STATUS_SECOND 6'h11
`define SEI_IDX_STATUS_THIRD  6'h12
`define SEI_IDX_STATUS_FOURTH 6'h13
`define SEI_IDX_STATUS_FIFTH  6'h14
`define SEI_IDX_ENABLE_SECOND 6'h17
`define SEI_IDX_ENABLE_THIRD  6'h18
`define SEI_IDX_ENABLE_FOURTH 6'h19
`define SEI_IDX_ENABLE_FIFTH  6'h1a
`define SEI_IDX_RESERVED      6'h1b
// implemented bit masks
`define SEI_MASK_SECOND 8'hf7
`define SEI_MASK_SRC2   8'h17
`define SEI_MASK_THIRD  8'hf7
`define SEI_MASK_FOURTH 8'hff
`define SEI_MASK_FIFTH  8'hcf
// field positions in the second enable register
`define SEI_BIT_MOUSE   0
`define SEI_BIT_KBD     1
`define SEI_BIT_IR      2
`define SEI_BIT_PORT12  4
`define SEI_BIT_TO_PME  5
`define SEI_BIT_TO_SER  6
`define SEI_BIT_TO_PIN  7
// reset values
`define SEI_RST_BYTE    8'h00
// axi responses
`define SEI_RESP_OKAY   2'b00
`define SEI_RESP_SLVERR 2'b10
`endif

// ---- common/sei_pkg.sv ----
// types shared by the management irq enable stage
`default_nettype none
package sei_pkg;
    typedef logic [7:0]  sei_byte_t;   // one register byte
    typedef logic [23:0] sei_src_t;    // gpio/fan sources, third..fifth
    typedef logic [5:0]  sei_idx_t;    // register index
endpackage : sei_pkg
`default_nettype wire

// ---- rtl/sei_smi_route.sv ----
// management irq enable and routing stage with axi4-lite register slave
//
// Summary of operation
// - mouse, keyboard, infrared, port12 enables gate group
// - gpio and fan enables, one bit each
// - group routed to pin, serirq, pme independently
// - second enable bit 7 drives output pin
// - second enable bit 6 drives serial irq
// - second enable bit 5 feeds pme logic
// - register after fifth enable reads zero
// - gpio and fan status cleared by one
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sei_defines.svh"
module sei_smi_route (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // level sources from on-chip logic, cleared at their origin
    input  wire logic        mouse_irq,
    input  wire logic        keyboard_irq,
    input  wire logic        infrared_irq,
    input  wire logic        port12_irq,
    // pin sources, asynchronous
    input  wire logic        gpio_pin_20,
    input  wire logic        gpio_pin_21,
    input  wire logic        gpio_pin_22,
    input  wire logic        gpio_pin_24,
    input  wire logic        gpio_pin_25,
    input  wire logic        gpio_pin_26,
    input  wire logic        gpio_pin_60,
    input  wire logic        gpio_pin_30,
    input  wire logic        gpio_pin_31,
    input  wire logic        gpio_pin_32,
    input  wire logic        gpio_pin_33,
    input  wire logic        gpio_pin_41,
    input  wire logic        gpio_pin_42,
    input  wire logic        gpio_pin_43,
    input  wire logic        gpio_pin_61,
    input  wire logic        gpio_pin_54,
    input  wire logic        gpio_pin_55,
    input  wire logic        gpio_pin_56,
    input  wire logic        gpio_pin_57,
    input  wire logic        fan_speed_input_a,
    input  wire logic        fan_speed_input_b,
    // routed outputs
    output logic             group_mgmt_irq,
    output logic             mgmt_irq_out_pin_n,
    output logic             group_to_serirq,
    output logic             group_to_pme
);

    // all checks share this clock and stay quiet while reset is held
    default clocking cb_sei @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // true for an index that holds a register (reserved one included)
    function automatic logic sei_mapped(input sei_pkg::sei_idx_t idx);
        case (idx)
            `SEI_IDX_STATUS_SECOND, `SEI_IDX_STATUS_THIRD,
            `SEI_IDX_STATUS_FOURTH, `SEI_IDX_STATUS_FIFTH,
            `SEI_IDX_ENABLE_SECOND, `SEI_IDX_ENABLE_THIRD,
            `SEI_IDX_ENABLE_FOURTH, `SEI_IDX_ENABLE_FIFTH,
            `SEI_IDX_RESERVED: sei_mapped = 1'b1;
            default:           sei_mapped = 1'b0;
        endcase
    endfunction : sei_mapped

    sei_pkg::sei_src_t  pin_raw;      // raw pins, reserved slots tied low
    sei_pkg::sei_src_t  sync1_r;      // first synchroniser stage
    sei_pkg::sei_src_t  sync2_r;      // second synchroniser stage
    sei_pkg::sei_src_t  prev_r;       // delayed copy for edge detection
    sei_pkg::sei_src_t  src_set;      // rising-edge events
    sei_pkg::sei_src_t  src_mask;     // implemented source positions
    sei_pkg::sei_src_t  status_r;     // sticky gpio/fan status
    sei_pkg::sei_src_t  status_nxt;   // next sticky status
    sei_pkg::sei_src_t  clr_vec;      // write-one-to-clear pulses
    sei_pkg::sei_byte_t en2_r;        // second enable register
    sei_pkg::sei_byte_t en3_r;        // third enable register
    sei_pkg::sei_byte_t en4_r;        // fourth enable register
    sei_pkg::sei_byte_t en5_r;        // fifth enable register
    sei_pkg::sei_byte_t src2;         // level sources in second layout
    logic               group_any;    // combined enabled request
    logic               aw_hold_r;    // write address captured
    logic               w_hold_r;     // write data captured
    sei_pkg::sei_idx_t  aw_idx_r;     // captured write index
    sei_pkg::sei_byte_t wdata_r;      // captured write byte
    logic               wstrb0_r;     // captured lane 0 strobe
    logic               wr_go;        // write performed this edge
    logic               wr_lane;      // write really stores a byte
    sei_pkg::sei_idx_t  ar_idx;       // read index
    sei_pkg::sei_byte_t rd_val;       // read value before the flop

    assign pin_raw = {fan_speed_input_b, fan_speed_input_a, 2'b00,
                      gpio_pin_57, gpio_pin_56, gpio_pin_55, gpio_pin_54,
                      gpio_pin_61, gpio_pin_43, gpio_pin_42, gpio_pin_41,
                      gpio_pin_33, gpio_pin_32, gpio_pin_31, gpio_pin_30,
                      gpio_pin_60, gpio_pin_26, gpio_pin_25, gpio_pin_24,
                      1'b0, gpio_pin_22, gpio_pin_21, gpio_pin_20};
    assign src_mask = {`SEI_MASK_FIFTH, `SEI_MASK_FOURTH, `SEI_MASK_THIRD};
    // two-flop synchroniser and edge detector per pin source
    genvar gi;
    generate
        for (gi = 0; gi < 24; gi++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    prev_r[gi]  <= 1'b0;
                end else begin
                    sync1_r[gi] <= pin_raw[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    prev_r[gi]  <= sync2_r[gi];
                end
            end
            // reserved slots never raise an event
            assign src_set[gi] = sync2_r[gi] & ~prev_r[gi] & src_mask[gi];
        end
    endgenerate
    // write handshake: both channels held until the response is taken
    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
    assign wr_go         = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign wr_lane       = wr_go && wstrb0_r;
    // capture write address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            aw_idx_r  <= 6'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_idx_r  <= s_axi_awaddr[7:2];
        end else if (wr_go) begin
            aw_hold_r <= 1'b0;
        end
    end
    // capture write data, lane 0 only carries register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_r <= 1'b0;
            wdata_r  <= `SEI_RST_BYTE;
            wstrb0_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_hold_r <= 1'b0;
        end
    end
    // write response; unmapped address answers slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SEI_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= sei_mapped(aw_idx_r) ? `SEI_RESP_OKAY : `SEI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    // enable registers; reserved bits cannot be set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en2_r <= `SEI_RST_BYTE;
            en3_r <= `SEI_RST_BYTE;
            en4_r <= `SEI_RST_BYTE;
            en5_r <= `SEI_RST_BYTE;
        end else if (wr_lane) begin
            case (aw_idx_r)
                `SEI_IDX_ENABLE_SECOND: en2_r <= wdata_r & `SEI_MASK_SECOND;
                `SEI_IDX_ENABLE_THIRD:  en3_r <= wdata_r & `SEI_MASK_THIRD;
                `SEI_IDX_ENABLE_FOURTH: en4_r <= wdata_r & `SEI_MASK_FOURTH;
                `SEI_IDX_ENABLE_FIFTH:  en5_r <= wdata_r & `SEI_MASK_FIFTH;
                // reserved index and the rest: write ignored
                default: ;
            endcase
        end
    end
    // clear pulses from writes of one to a status register
    always_comb begin
        clr_vec = 24'h00_0000;
        if (wr_lane) begin
            case (aw_idx_r)
                `SEI_IDX_STATUS_THIRD:  clr_vec[7:0]   = wdata_r;
                `SEI_IDX_STATUS_FOURTH: clr_vec[15:8]  = wdata_r;
                `SEI_IDX_STATUS_FIFTH:  clr_vec[23:16] = wdata_r;
                default:                clr_vec        = 24'h00_0000;
            endcase
        end
    end
    // sticky status: an edge in the clearing cycle survives the clear
    assign status_nxt = ((status_r & ~clr_vec) | src_set) & src_mask;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= 24'h00_0000;
        end else begin
            status_r <= status_nxt;
        end
    end
    // level sources placed at their enable positions
    always_comb begin
        src2                  = `SEI_RST_BYTE;
        src2[`SEI_BIT_MOUSE]  = mouse_irq;
        src2[`SEI_BIT_KBD]    = keyboard_irq;
        src2[`SEI_BIT_IR]     = infrared_irq;
        src2[`SEI_BIT_PORT12] = port12_irq;
    end
    // combine every enabled flag into one group request
    assign group_any = |(src2 & en2_r & `SEI_MASK_SRC2)
                     | |(status_r & {en5_r, en4_r, en3_r});
    // registered group request and its three destinations
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            group_mgmt_irq     <= 1'b0;
            mgmt_irq_out_pin_n <= 1'b1;
            group_to_serirq    <= 1'b0;
            group_to_pme       <= 1'b0;
        end else begin
            group_mgmt_irq     <= group_any;
            mgmt_irq_out_pin_n <= !(group_any && en2_r[`SEI_BIT_TO_PIN]);
            group_to_serirq    <= group_any && en2_r[`SEI_BIT_TO_SER];
            group_to_pme       <= group_any && en2_r[`SEI_BIT_TO_PME];
        end
    end
    // read path: one request at a time, data one edge after address
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_idx        = s_axi_araddr[7:2];

    always_comb begin
        case (ar_idx)
            `SEI_IDX_STATUS_SECOND: rd_val = src2;
            `SEI_IDX_STATUS_THIRD:  rd_val = status_r[7:0];
            `SEI_IDX_STATUS_FOURTH: rd_val = status_r[15:8];
            `SEI_IDX_STATUS_FIFTH:  rd_val = status_r[23:16];
            `SEI_IDX_ENABLE_SECOND: rd_val = en2_r;
            `SEI_IDX_ENABLE_THIRD:  rd_val = en3_r;
            `SEI_IDX_ENABLE_FOURTH: rd_val = en4_r;
            `SEI_IDX_ENABLE_FIFTH:  rd_val = en5_r;
            default:                rd_val = `SEI_RST_BYTE;
        endcase
    end

    // read data register; upper bits always zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `SEI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_val};
            s_axi_rresp  <= sei_mapped(ar_idx) ? `SEI_RESP_OKAY : `SEI_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    // checks next to the logic they guard
    property p_pin_follows;
        (group_any && en2_r[`SEI_BIT_TO_PIN]) |=> !mgmt_irq_out_pin_n;
    endproperty
    a_pin_follows: assert property (p_pin_follows)
        else $error("output pin not driven low by enabled group");
    property p_pin_blocked;
        !$past(en2_r[`SEI_BIT_TO_PIN]) && $past(aresetn) |-> mgmt_irq_out_pin_n;
    endproperty
    a_pin_blocked: assert property (p_pin_blocked)
        else $error("output pin low while its gate is off");
    property p_serirq;
        ##1 group_to_serirq == ($past(group_any) && $past(en2_r[`SEI_BIT_TO_SER]));
    endproperty
    a_serirq: assert property (p_serirq)
        else $error("serial irq path mismatch");
    property p_pme;
        group_to_pme |-> group_mgmt_irq && $past(en2_r[`SEI_BIT_TO_PME]);
    endproperty
    a_pme: assert property (p_pme)
        else $error("pme path active without group or gate");
    property p_mouse_gate;
        (mouse_irq && en2_r[`SEI_BIT_MOUSE]) |=> group_mgmt_irq;
    endproperty
    a_mouse_gate: assert property (p_mouse_gate)
        else $error("enabled mouse source missed");
    property p_gpio_gate;
        (status_r[0] && en3_r[0]) |=> group_mgmt_irq;
    endproperty
    a_gpio_gate: assert property (p_gpio_gate)
        else $error("enabled gpio source missed");
    property p_group_idle;
        (src2 & en2_r) == 8'h00 && (status_r & {en5_r, en4_r, en3_r}) == 24'h00_0000
        |=> !group_mgmt_irq;
    endproperty
    a_group_idle: assert property (p_group_idle)
        else $error("group asserted with no enabled flag");
    property p_clear_one;
        clr_vec[8] && !src_set[8] |=> !status_r[8];
    endproperty
    a_clear_one: assert property (p_clear_one)
        else $error("status bit not cleared by one");
    property p_set_wins;
        src_set[9] |=> status_r[9];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("edge lost against clear");
    property p_reserved_zero;
        (s_axi_arvalid && s_axi_arready && ar_idx == `SEI_IDX_RESERVED)
        |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved register read not zero");
    property p_route_indep;
        group_mgmt_irq && !$past(en2_r[`SEI_BIT_TO_SER]) |-> !group_to_serirq;
    endproperty
    a_route_indep: assert property (p_route_indep)
        else $error("serial path active with gate off");

endmodule : sei_smi_route
`default_nettype wire

// ---- sim/sei_host_model.sv ----
// host model that counts routed management interrupt requests
`timescale 1ns/1ps
`default_nettype none
module sei_host_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       pin_n,
    input  wire logic       serirq,
    input  wire logic       pme,
    output logic      [3:0] pin_cnt_r,
    output logic      [3:0] ser_cnt_r,
    output logic      [3:0] pme_cnt_r
);
    logic [2:0] prev_r; // last levels, pin taken in its active-high sense
    // a held level is one request, so only new assertions are counted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_r    <= 3'h0;
            pin_cnt_r <= 4'h0;
            ser_cnt_r <= 4'h0;
            pme_cnt_r <= 4'h0;
        end else begin
            prev_r <= {~pin_n, serirq, pme};
            if (~pin_n && !prev_r[2]) pin_cnt_r <= pin_cnt_r + 4'h1;
            if (serirq && !prev_r[1]) ser_cnt_r <= ser_cnt_r + 4'h1;
            if (pme && !prev_r[0]) pme_cnt_r <= pme_cnt_r + 4'h1;
        end
    end
endmodule : sei_host_model
`default_nettype wire

// ---- sim/sei_smi_route_test.sv ----
// self-checking bench for the management irq enable and routing stage
`timescale 1ns/1ps
`default_nettype none
`define SEI_CHK(nm, ev, g) begin check_count++; if ((g) !== (ev)) begin fail_count++; \
    $display("unexpected %s: expected %h seen %h", nm, ev, g); end end
module sei_smi_route_test;
    logic        aclk    = 1'b0;          // 100 MHz clock
    logic        aresetn = 1'b0;          // held low for the first ten edges
    logic [31:0] awaddr  = 32'h0000_0000;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [31:0] araddr  = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic [3:0]  wstrb   = 4'hf;          // write lane strobes
    logic [3:0]  lvl_r   = 4'h0;          // mouse, keyboard, infrared, port12
    logic [23:0] src_r   = 24'h00_0000;   // pins in status bit order
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        grp, pin_n, ser, pme;    // routed outputs
    logic [3:0]  pin_cnt, ser_cnt, pme_cnt;
    int          fail_count  = 0;
    int          check_count = 0;
    int          cycles      = 0;

    // free running clock
    always #5 aclk = ~aclk;

    sei_smi_route sei_smi_route_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .mouse_irq(lvl_r[0]), .keyboard_irq(lvl_r[1]), .infrared_irq(lvl_r[2]),
        .port12_irq(lvl_r[3]),
        .gpio_pin_20(src_r[0]), .gpio_pin_21(src_r[1]), .gpio_pin_22(src_r[2]),
        .gpio_pin_24(src_r[4]), .gpio_pin_25(src_r[5]), .gpio_pin_26(src_r[6]),
        .gpio_pin_60(src_r[7]), .gpio_pin_30(src_r[8]), .gpio_pin_31(src_r[9]),
        .gpio_pin_32(src_r[10]), .gpio_pin_33(src_r[11]), .gpio_pin_41(src_r[12]),
        .gpio_pin_42(src_r[13]), .gpio_pin_43(src_r[14]), .gpio_pin_61(src_r[15]),
        .gpio_pin_54(src_r[16]), .gpio_pin_55(src_r[17]), .gpio_pin_56(src_r[18]),
        .gpio_pin_57(src_r[19]), .fan_speed_input_a(src_r[22]),
        .fan_speed_input_b(src_r[23]),
        .group_mgmt_irq(grp), .mgmt_irq_out_pin_n(pin_n),
        .group_to_serirq(ser), .group_to_pme(pme)
    );

    sei_host_model sei_host_model_inst (
        .aclk(aclk), .aresetn(aresetn), .pin_n(pin_n), .serirq(ser), .pme(pme),
        .pin_cnt_r(pin_cnt), .ser_cnt_r(ser_cnt), .pme_cnt_r(pme_cnt)
    );

    // one write; upper data bits carry junk that the slave must drop
    task automatic axi_write(input logic [5:0] idx, input logic [7:0] val,
                             input logic [1:0] rsp);
        @(posedge aclk);
        awaddr  <= {24'h00_0000, idx, 2'b00};
        wdata   <= {24'hab_cdef, val};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        `SEI_CHK("bvalid", 1'b1, bvalid)
        `SEI_CHK("bresp", rsp, bresp)
    endtask : axi_write

    // one read, data compared whole so upper bits must read zero
    task automatic axi_read(input logic [5:0] idx, input logic [7:0] ev,
                            input logic [1:0] rsp);
        @(posedge aclk);
        araddr  <= {24'h00_0000, idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        `SEI_CHK("rvalid", 1'b1, rvalid)
        `SEI_CHK("rresp", rsp, rresp)
        `SEI_CHK("rdata", {24'h00_0000, ev}, rdata)
    endtask : axi_read

    // reset values, writable bits, reserved slot and an unmapped index
    task automatic test_regs;
        logic [7:0] msk [5] = '{8'hf7, 8'hf7, 8'hff, 8'hcf, 8'h00};
        for (int i = 0; i < 5; i++) begin
            axi_read(6'(6'h17 + i), 8'h00, 2'b00);
            axi_write(6'(6'h17 + i), 8'hff, 2'b00);
            axi_read(6'(6'h17 + i), msk[i], 2'b00);
        end
        axi_write(6'h30, 8'hff, 2'b10);
        axi_read(6'h30, 8'h00, 2'b10);
        for (int i = 0; i < 4; i++) axi_write(6'(6'h17 + i), 8'h00, 2'b00);
        // lane 0 strobe off: answered, but nothing is stored
        wstrb <= 4'he;
        axi_write(6'h18, 8'hff, 2'b00);
        axi_read(6'h18, 8'h00, 2'b00);
        wstrb <= 4'hf;
    endtask : test_regs

    // each level source twice, all eight route combinations in turn
    task automatic test_route;
        logic [7:0] en;
        int         sb;
        for (int i = 0; i < 8; i++) begin
            sb = (i % 4 == 3) ? 4 : i % 4;
            en = 8'(i << 5);
            axi_write(6'h17, en, 2'b00);
            lvl_r[i % 4] <= 1'b1;
            repeat (3) @(posedge aclk);
            `SEI_CHK("group_masked", 1'b0, grp)
            axi_write(6'h17, en | 8'(1 << sb), 2'b00);
            repeat (3) @(posedge aclk);
            `SEI_CHK("group_on", 1'b1, grp)
            `SEI_CHK("pin_n", ~en[7], pin_n)
            `SEI_CHK("serirq", en[6], ser)
            `SEI_CHK("pme", en[5], pme)
            axi_read(6'h11, 8'(1 << sb), 2'b00);
            lvl_r[i % 4] <= 1'b0;
            repeat (3) @(posedge aclk);
            `SEI_CHK("group_off", 1'b0, grp)
            `SEI_CHK("pin_idle", 1'b1, pin_n)
        end
        axi_write(6'h17, 8'h00, 2'b00);
        `SEI_CHK("host_pin", 4'h4, pin_cnt)
        `SEI_CHK("host_ser", 4'h4, ser_cnt)
        `SEI_CHK("host_pme", 4'h4, pme_cnt)
    endtask : test_route

    // every pin source: masked, unmasked, then cleared by a written one
    task automatic test_gpio;
        logic [7:0] b;
        for (int p = 0; p < 24; p++) begin
            if (p == 3 || p == 20 || p == 21) continue;
            b = 8'(1 << (p % 8));
            src_r[p] <= 1'b1;
            repeat (6) @(posedge aclk);
            `SEI_CHK("pin_masked", 1'b0, grp)
            axi_write(6'(6'h18 + p / 8), b, 2'b00);
            repeat (2) @(posedge aclk);
            `SEI_CHK("pin_group", 1'b1, grp)
            axi_read(6'(6'h12 + p / 8), b, 2'b00);
            src_r[p] <= 1'b0;
            axi_write(6'(6'h12 + p / 8), b, 2'b00);
            repeat (2) @(posedge aclk);
            `SEI_CHK("pin_cleared", 1'b0, grp)
            axi_read(6'(6'h12 + p / 8), 8'h00, 2'b00);
            axi_write(6'(6'h18 + p / 8), 8'h00, 2'b00);
        end
    endtask : test_gpio

    // verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    // hang guard, far above the fewer than one thousand cycles the tests need
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test;
        end
    end

    // main sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        test_regs;
        test_route;
        test_gpio;
        finish_test;
    end
endmodule : sei_smi_route_test
`default_nettype wire
